/* File: common/afsh_pkg.sv */
package afsh_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_FREQ_KHZ     = 200000;
	localparam int unsigned STROBE_DELAY_MS  = 64;
	localparam int unsigned STROBE_DELAY_CYC = STROBE_DELAY_MS * CLK_FREQ_KHZ;
	localparam int unsigned DONE_HOLD_NS     = 1000;
	localparam int unsigned DONE_HOLD_CYC    = (DONE_HOLD_NS * CLK_FREQ_KHZ + 999999) / 1000000;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_SPINDLE     = 8'h04;
	localparam logic [7:0] OFS_TOOL        = 8'h08;
	localparam logic [7:0] OFS_MCODE1      = 8'h0C;
	localparam logic [7:0] OFS_MCODE2      = 8'h10;
	localparam logic [7:0] OFS_MCODE3      = 8'h14;
	localparam logic [7:0] OFS_CMD         = 8'h18;
	localparam logic [7:0] OFS_GEAR_MAX0   = 8'h1C;
	localparam logic [7:0] OFS_STRB_DELAY  = 8'h2C;
	localparam logic [7:0] OFS_HOLD_TIME   = 8'h30;
	localparam logic [7:0] OFS_STATUS      = 8'h34;
	localparam logic [7:0] OFS_LOCK_IN     = 8'h38;
	localparam logic [7:0] OFS_LOCK_ECHO   = 8'h3C;
	localparam logic [7:0] OFS_SPIN_STATE  = 8'h40;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_ANALOG      = 0;
	localparam int CTRL_AUTO_MDI    = 1;
	localparam int CMD_SPINDLE      = 0;
	localparam int CMD_TOOL         = 1;
	localparam int CMD_M1           = 2;
	localparam int CMD_MCALL_LSB    = 5;
	localparam int ST_BUSY          = 0;
	localparam int ST_BLOCK_DONE    = 1;
	localparam int ST_ALARM         = 2;
	localparam int LOCK_IN_BIT      = 6;
	localparam int LOCK_ECHO_BIT    = 4;

	// ----------------------------------------
	// Reset values and code limits
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST       = 32'h0000_0002;
	localparam logic [31:0] GEAR_MAX_RST   = 32'h0000_FFFF;
	localparam logic [31:0] SPIN_IO_MIN    = 32'h0000_0001;
	localparam logic [31:0] SPIN_IO_MAX    = 32'h0000_0008;
	localparam logic [31:0] TOOL_MAX       = 32'h0000_0063;
	localparam logic [31:0] MCODE_STOP     = 32'h0000_0000;
	localparam logic [31:0] MCODE_OPT_STOP = 32'h0000_0001;
	localparam logic [31:0] MCODE_END      = 32'h0000_0002;
	localparam logic [31:0] MCODE_END_RW   = 32'h0000_001E;
	localparam logic [31:0] MCODE_SUB_CALL = 32'h0000_0062;
	localparam logic [31:0] MCODE_SUB_RET  = 32'h0000_0063;

	typedef enum logic [3:0] {
		SQ_IDLE    = 4'b0001,
		SQ_PRESENT = 4'b0010,
		SQ_STROBE  = 4'b0100,
		SQ_RELEASE = 4'b1000
	} afsh_state_e;

endpackage

/* File: sim/afsh_plc_model.sv */
`timescale 1ns/1ps
module afsh_plc_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       strobeAny,
	input  wire logic [7:0] lagCyc,
	output logic            auxDoneAck
);
	// ------
	// Done handshake
	// ------
	logic [7:0] cnt_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r      <= 8'h00;
			auxDoneAck <= 1'b0;
		end
		else if (!strobeAny)
		begin
			cnt_r      <= 8'h00;
			auxDoneAck <= 1'b0;
		end
		else if (cnt_r < lagCyc)
			cnt_r <= cnt_r + 8'h01;
		else
			auxDoneAck <= 1'b1;
	end
endmodule // afsh_plc_model

/* File: sim/afsh_strobe_handshake_chk.sv */
`timescale 1ns/1ps
module afsh_strobe_handshake_chk #(
	parameter int unsigned STROBE_DELAY_DEF = 8
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        auxDoneAck,
	input wire logic        auxLockIn,
	input wire logic [31:0] spindleCode,
	input wire logic [3:0]  gearSelectBits,
	input wire logic [31:0] toolCode,
	input wire logic [31:0] mcodeFirst,
	input wire logic [15:0] mcodeSecond,
	input wire logic [15:0] mcodeThird,
	input wire logic        spindleStrobe,
	input wire logic        toolStrobe,
	input wire logic        mcodeStrobeFirst,
	input wire logic        mcodeStrobeSecond,
	input wire logic        mcodeStrobeThird,
	input wire logic        auxLockEcho,
	input wire logic        auxBusy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------
	// Helper logic
	// ------
	localparam int unsigned HOLD_DEF = afsh_pkg::DONE_HOLD_CYC;
	logic        strb;
	logic        codesZero;
	logic [1:0]  age_r;
	logic [31:0] busyCnt_r;
	logic [15:0] doneCnt_r;

	assign strb = spindleStrobe | toolStrobe | mcodeStrobeFirst | mcodeStrobeSecond
		| mcodeStrobeThird;
	assign codesZero = (spindleCode | toolCode | mcodeFirst) == 32'h0
		&& (mcodeSecond | mcodeThird) == 16'h0 && gearSelectBits == 4'h0;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			age_r <= 2'h0;
		else if (age_r != 2'h3)
			age_r <= age_r + 2'h1;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			busyCnt_r <= 32'h0;
		else
			busyCnt_r <= auxBusy ? busyCnt_r + 32'h1 : 32'h0;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			doneCnt_r <= 16'h0;
		else if (!auxDoneAck)
			doneCnt_r <= 16'h0;
		else if (doneCnt_r != 16'hFFFF)
			doneCnt_r <= doneCnt_r + 16'h1;

	// ------
	// Assertions
	// ------
	sequence doneDrop;
		!strb ##0 $fell(auxDoneAck);
	endsequence
	sequence allClear;
		codesZero && !auxBusy;
	endsequence

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait OKAY");
	echo_follow_a: assert property (age_r == 2'h3 |-> auxLockEcho == $past(auxLockIn, 2))
		else $error("lock echo differs from lock input");
	gear_onehot_a: assert property ($onehot0(gearSelectBits))
		else $error("more than one gear bit set");
	strobe_delay_a: assert property ($rose(strb) |-> busyCnt_r >= STROBE_DELAY_DEF)
		else $error("strobe rose before the delay ran out");
	strobe_hold_a: assert property ($fell(strb) |-> doneCnt_r > HOLD_DEF)
		else $error("strobe fell before done was held long enough");
	strobe_keep_a: assert property (strb && !auxDoneAck |=> strb)
		else $error("strobe fell while done was low");
	codes_stable_a: assert property (strb && $past(strb) |->
		$stable(spindleCode) && $stable(toolCode) && $stable(mcodeFirst))
		else $error("codes moved while strobe high");
	codes_clear_a: assert property (doneDrop |-> ##[1:3] allClear)
		else $error("codes not cleared after done dropped");
	strobe_idle_a: assert property (!auxBusy |-> !strb)
		else $error("strobe high while not busy");
endmodule // afsh_strobe_handshake_chk

bind afsh_strobe_handshake afsh_strobe_handshake_chk #(.STROBE_DELAY_DEF(STROBE_DELAY_DEF)) u_chk (
	.clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
	.auxDoneAck(auxDoneAck), .auxLockIn(auxLockIn), .spindleCode(spindleCode),
	.gearSelectBits(gearSelectBits), .toolCode(toolCode), .mcodeFirst(mcodeFirst),
	.mcodeSecond(mcodeSecond), .mcodeThird(mcodeThird), .spindleStrobe(spindleStrobe),
	.toolStrobe(toolStrobe), .mcodeStrobeFirst(mcodeStrobeFirst),
	.mcodeStrobeSecond(mcodeStrobeSecond), .mcodeStrobeThird(mcodeStrobeThird),
	.auxLockEcho(auxLockEcho), .auxBusy(auxBusy)
);

/* File: sim/afsh_strobe_handshake_tb.sv */
`timescale 1ns/1ps
module afsh_strobe_handshake_tb;
	import afsh_pkg::*;

	// ------
	// Signals and tables
	// ------
	localparam int unsigned DLY = 8;
	localparam logic [31:0] GM [4] = '{32'h3E8, 32'h7D0, 32'hBB8, 32'hFA0};
	localparam logic [31:0] CV [4] = '{32'h3E8, 32'h3E9, 32'hFA0, 32'hFA1};
	localparam logic [31:0] MC [6] = '{MCODE_STOP, MCODE_OPT_STOP, MCODE_END, MCODE_END_RW,
		32'h3, MCODE_SUB_CALL};
	localparam logic [7:0]  RA [5] = '{OFS_CTRL, OFS_GEAR_MAX0, OFS_STRB_DELAY, 8'h44,
		OFS_LOCK_ECHO};
	localparam logic [31:0] RV [5] = '{CTRL_RST, GEAR_MAX_RST, 32'(DLY), 32'h0, 32'h0};
	logic        clk, rst_n, clkEn, hsel, hwrite, auxLockIn, sDone;
	logic        hreadyout, hresp, auxDoneAck, auxLockEcho, auxBusy, spindleAlarm;
	logic        spindleStrobe, toolStrobe, mcodeStrobeFirst, mcodeStrobeSecond;
	logic        mcodeStrobeThird;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  gearSelectBits, sGear;
	logic [4:0]  sStrb;
	logic [7:0]  lagCyc;
	logic [15:0] mcodeSecond, mcodeThird, sM2, sM3;
	logic [31:0] haddr, hwdata, hrdata, rd, v, spindleCode, toolCode, mcodeFirst;
	logic [31:0] spindleAnalogValue, sSc, sTc, sM1;
	logic [31:0] mv [3];
	int          mismatches, n_checks;
	wire  [4:0]  strbV = {mcodeStrobeThird, mcodeStrobeSecond, mcodeStrobeFirst, toolStrobe,
		spindleStrobe};

	afsh_strobe_handshake #(.STROBE_DELAY_DEF(DLY)) dut (
		.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .auxDoneAck(auxDoneAck), .auxLockIn(auxLockIn),
		.spindleCode(spindleCode), .gearSelectBits(gearSelectBits), .toolCode(toolCode),
		.mcodeFirst(mcodeFirst), .mcodeSecond(mcodeSecond), .mcodeThird(mcodeThird),
		.spindleStrobe(spindleStrobe), .toolStrobe(toolStrobe),
		.mcodeStrobeFirst(mcodeStrobeFirst), .mcodeStrobeSecond(mcodeStrobeSecond),
		.mcodeStrobeThird(mcodeStrobeThird), .auxLockEcho(auxLockEcho),
		.spindleAnalogValue(spindleAnalogValue), .auxBusy(auxBusy), .spindleAlarm(spindleAlarm)
	);

	afsh_plc_model plc (
		.clk(clk), .rst_n(rst_n), .strobeAny(|strbV), .lagCyc(lagCyc), .auxDoneAck(auxDoneAck)
	);

	// ------
	// Tasks and expectations
	// ------
	function automatic logic [31:0] ohot(input logic [31:0] n);
		return (n >= 32'h1 && n <= 32'h8) ? 32'h1 << (n - 32'h1) : 32'h0;
	endfunction

	function automatic logic [3:0] gearOf(input logic [31:0] val);
		for (int g = 0; g < 4; g++)
			if (GM[g] >= val)
				return 4'h1 << g;
		return 4'h8;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do
			@(posedge clk);
		while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge clk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic go(input logic [7:0] cmd, input logic alarm);
		int k;
		lagCyc <= 8'($urandom_range(2, 40));
		bus(1'b1, OFS_CMD, {24'h0, cmd});
		for (k = 0; k < 3 * DLY && strbV === 5'h00; k++)
			@(posedge clk);
		sStrb = strbV;
		sSc   = spindleCode;
		sTc   = toolCode;
		sGear = gearSelectBits;
		sM1   = mcodeFirst;
		sM2   = mcodeSecond;
		sM3   = mcodeThird;
		sDone = auxDoneAck;
		if (sStrb !== 5'h00)
			check("done at strobe", 32'(sDone), 32'h0);
		for (k = 0; k < 1000 && auxBusy !== 1'b0; k++)
			@(posedge clk);
		check("alarm pin", 32'(spindleAlarm), 32'(alarm));
		bus(1'b0, OFS_STATUS, 32'h0);
		check("block done", 32'(rd[ST_BLOCK_DONE]), 32'h1);
		check("busy flag", 32'(rd[ST_BUSY]), 32'h0);
		check("alarm flag", 32'(rd[ST_ALARM]), 32'(alarm));
		bus(1'b1, OFS_STATUS, 32'h6);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		#(40000 * 5);
		mismatches++;
		results();
	end

	// ------
	// Scenarios
	// ------
	initial
	begin
		rst_n     = 1'b0;
		clkEn     = 1'b1;
		hsel      = 1'b0;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		haddr     = 32'h0;
		hwdata    = 32'h0;
		auxLockIn = 1'b0;
		lagCyc    = 8'h02;
		void'($urandom(68822));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b1, 8'h44, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, RA[i], 32'h0);
			check("reset value", rd, RV[i]);
		end
		for (int n = 0; n < 12; n++)
		begin
			v = (n < 10) ? 32'(n) : 32'($urandom_range(1, 8));
			bus(1'b1, OFS_SPINDLE, v);
			go(8'h01, v < 32'h1 || v > 32'h8);
			check("spindle strobe", 32'(sStrb), ohot(v) != 32'h0 ? 32'h1 : 32'h0);
			check("spindle code", sSc, ohot(v));
		end
		bus(1'b1, OFS_CTRL, 32'h3);
		for (int g = 0; g < 4; g++)
			bus(1'b1, 8'(OFS_GEAR_MAX0 + 4 * g), GM[g]);
		for (int i = 0; i < 7; i++)
		begin
			v = (i < 4) ? CV[i] : 32'($urandom_range(1, 4000));
			bus(1'b1, OFS_SPINDLE, v);
			go(8'h01, 1'b0);
			check("analog strobe", 32'(sStrb), 32'h1);
			check("analog code", sSc, v);
			check("gear bits", 32'(sGear), 32'(gearOf(v)));
			check("analog value", spindleAnalogValue, v);
		end
		bus(1'b1, OFS_CTRL, CTRL_RST);
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? TOOL_MAX : (i == 1) ? 32'h0000_01F4 : 32'($urandom_range(0, 99));
			bus(1'b1, OFS_TOOL, v);
			for (int s = 0; s < 3; s++)
			begin
				mv[s] = 32'($urandom_range(3, 97));
				bus(1'b1, 8'(OFS_MCODE1 + 4 * s), mv[s]);
			end
			bus(1'b1, OFS_SPINDLE, 32'h5);
			go(8'h1F, 1'b0);
			check("all strobes", 32'(sStrb), 32'h1F);
			check("tool code", sTc, (v > TOOL_MAX) ? TOOL_MAX : v);
			check("first m", sM1, mv[0]);
			check("second m", 32'(sM2), mv[1]);
			check("third m", 32'(sM3), mv[2]);
		end
		bus(1'b1, OFS_MCODE1, MCODE_SUB_CALL);
		bus(1'b1, OFS_MCODE2, MCODE_SUB_RET);
		go(8'h9C, 1'b0);
		check("subprogram strobes", 32'(sStrb), 32'h0);
		check("subprogram code", sM1, 32'h0);
		fork
			go(8'h01, 1'b0);
			begin
				repeat (6) @(posedge clk);
				auxLockIn <= 1'b1;
			end
		join
		check("late lock strobe", 32'(sStrb), 32'h1);
		check("lock echo", 32'(auxLockEcho), 32'h1);
		bus(1'b0, OFS_LOCK_ECHO, 32'h0);
		check("echo register", 32'(rd[LOCK_ECHO_BIT]), 32'h1);
		bus(1'b1, OFS_CTRL, 32'h3);
		for (int i = 0; i < 6; i++)
		begin
			v = 32'($urandom_range(1, 4000));
			bus(1'b1, OFS_SPINDLE, v);
			bus(1'b1, OFS_MCODE1, MC[i]);
			go(8'h07, 1'b0);
			check("locked strobes", 32'(sStrb), (i < 4) ? 32'h4 : 32'h0);
			check("locked analog", spindleAnalogValue, v);
			bus(1'b0, OFS_SPIN_STATE, 32'h0);
			check("spindle state", rd, v);
		end
		bus(1'b1, OFS_CTRL, 32'h1);
		go(8'h03, 1'b0);
		check("manual lock strobes", 32'(sStrb), 32'h3);
		auxLockIn <= 1'b0;
		repeat (3) @(posedge clk);
		check("echo low", 32'(auxLockEcho), 32'h0);
		results();
	end
endmodule // afsh_strobe_handshake_tb

/* File: verilog/afsh_strobe_handshake.sv */
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module afsh_strobe_handshake #(
	parameter int unsigned STROBE_DELAY_DEF = afsh_pkg::STROBE_DELAY_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        auxDoneAck,
	input  wire logic        auxLockIn,
	output logic      [31:0] spindleCode,
	output logic      [3:0]  gearSelectBits,
	output logic      [31:0] toolCode,
	output logic      [31:0] mcodeFirst,
	output logic      [15:0] mcodeSecond,
	output logic      [15:0] mcodeThird,
	output logic             spindleStrobe,
	output logic             toolStrobe,
	output logic             mcodeStrobeFirst,
	output logic             mcodeStrobeSecond,
	output logic             mcodeStrobeThird,
	output logic             auxLockEcho,
	output logic      [31:0] spindleAnalogValue,
	output logic             auxBusy,
	output logic             spindleAlarm
);
	import afsh_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	afsh_state_e  state_r;
	logic [31:0]  ctrl_r, spinVal_r, toolVal_r, strbDelay_r, holdTime_r, spinState_r, cnt_r;
	logic [31:0]  mVal_r [3];
	logic [31:0]  gearMax_r [4];
	logic         lockReg_r, blockDone_r, alarm_r, ackSeenLow_r, doneSync_r, lockSync_r, wrPend_r;
	logic [7:0]   wrAddr_r;
	logic [4:0]   issue_r, issueNxt;
	logic [3:0]   gearFit, gearNxt;
	logic [2:0]   mStopClass, mSubCall;
	logic         addrPhase, cmdWrite, lockEff, spinBad, startSeq, finishSeq;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign auxBusy   = (state_r != SQ_IDLE);
	assign spindleAlarm = alarm_r;

	// ----------------------------------------
	// Input sampling
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{doneSync_r, lockSync_r, auxLockEcho} <= 3'h0;
		else if (clkEn)
		begin
			doneSync_r  <= auxDoneAck;
			lockSync_r  <= auxLockIn;
			auxLockEcho <= lockEff;
		end
	end

	assign lockEff = lockSync_r | lockReg_r;

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	assign addrPhase = hsel & htrans[1] & hready;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end
		else if (clkEn)
		begin
			wrPend_r <= addrPhase & hwrite;
			if (addrPhase)
				wrAddr_r <= haddr[7:0];
		end
	end

	assign cmdWrite = wrPend_r && (wrAddr_r == OFS_CMD);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r      <= CTRL_RST;
			spinVal_r   <= 32'h0000_0000;
			toolVal_r   <= 32'h0000_0000;
			mVal_r      <= '{3{32'h0000_0000}};
			strbDelay_r <= STROBE_DELAY_DEF;
			holdTime_r  <= DONE_HOLD_CYC;
			lockReg_r   <= 1'b0;
		end
		else if (clkEn && wrPend_r)
		begin
			case (wrAddr_r)
				OFS_CTRL:       ctrl_r      <= hwdata;
				OFS_SPINDLE:    spinVal_r   <= hwdata;
				OFS_TOOL:       toolVal_r   <= hwdata;
				OFS_MCODE1:     mVal_r[0]   <= hwdata;
				OFS_MCODE2:     mVal_r[1]   <= hwdata;
				OFS_MCODE3:     mVal_r[2]   <= hwdata;
				OFS_STRB_DELAY: strbDelay_r <= hwdata;
				OFS_HOLD_TIME:  holdTime_r  <= hwdata;
				OFS_LOCK_IN:    lockReg_r   <= hwdata[LOCK_IN_BIT];
				default:        ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_gear
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					gearMax_r[gi] <= GEAR_MAX_RST;
				else if (clkEn && wrPend_r && wrAddr_r == OFS_GEAR_MAX0 + 8'(gi * 4))
					gearMax_r[gi] <= hwdata;
			end
			assign gearFit[gi] = (spinVal_r <= gearMax_r[gi]);
		end
	endgenerate

	// Lowest gear whose maximum covers the code, else the top gear
	assign gearNxt = gearFit[0] ? 4'h1
		: gearFit[1] ? 4'h2
		: gearFit[2] ? 4'h4 : 4'h8;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_mdec
			assign mStopClass[gi] = (mVal_r[gi] == MCODE_STOP) || (mVal_r[gi] == MCODE_OPT_STOP)
				|| (mVal_r[gi] == MCODE_END) || (mVal_r[gi] == MCODE_END_RW);
			assign mSubCall[gi] = (mVal_r[gi] == MCODE_SUB_CALL)
				|| (mVal_r[gi] == MCODE_SUB_RET) || hwdata[CMD_MCALL_LSB + gi];
			assign issueNxt[CMD_M1 + gi] = hwdata[CMD_M1 + gi] && !mSubCall[gi]
				&& (!(lockEff && ctrl_r[CTRL_AUTO_MDI]) || mStopClass[gi]);
		end
	endgenerate

	assign spinBad = !ctrl_r[CTRL_ANALOG]
		&& ((spinVal_r < SPIN_IO_MIN) || (spinVal_r > SPIN_IO_MAX));
	assign issueNxt[CMD_SPINDLE] = hwdata[CMD_SPINDLE] && !spinBad
		&& !(lockEff && ctrl_r[CTRL_AUTO_MDI]);
	assign issueNxt[CMD_TOOL] = hwdata[CMD_TOOL]
		&& !(lockEff && ctrl_r[CTRL_AUTO_MDI]);

	// Commands written while a sequence runs are ignored
	assign startSeq = cmdWrite && (state_r == SQ_IDLE);

	// ----------------------------------------
	// Handshake sequencer
	// ----------------------------------------
	assign finishSeq = (state_r == SQ_RELEASE) && !doneSync_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r      <= SQ_IDLE;
			cnt_r        <= 32'h0000_0000;
			ackSeenLow_r <= 1'b0;
			issue_r      <= 5'h00;
		end
		else if (clkEn)
		begin
			case (state_r)
				SQ_IDLE:
				begin
					cnt_r        <= 32'h0000_0000;
					ackSeenLow_r <= 1'b0;
					if (startSeq && issueNxt != 5'h00)
					begin
						issue_r <= issueNxt;
						state_r <= SQ_PRESENT;
					end
				end
				SQ_PRESENT:
				begin
					if (cnt_r + 32'h0000_0001 >= strbDelay_r)
					begin
						cnt_r   <= 32'h0000_0000;
						state_r <= SQ_STROBE;
					end
					else
						cnt_r <= cnt_r + 32'h0000_0001;
				end
				SQ_STROBE:
				begin
					if (!doneSync_r)
					begin
						ackSeenLow_r <= 1'b1;
						cnt_r        <= 32'h0000_0000;
					end
					else if (ackSeenLow_r)
					begin
						if (cnt_r >= holdTime_r)
							state_r <= SQ_RELEASE;
						else
							cnt_r <= cnt_r + 32'h0000_0001;
					end
				end
				SQ_RELEASE:
				begin
					if (!doneSync_r)
					begin
						issue_r <= 5'h00;
						state_r <= SQ_IDLE;
					end
				end
				default:
					state_r <= SQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Strobes
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{spindleStrobe, toolStrobe, mcodeStrobeFirst, mcodeStrobeSecond,
				mcodeStrobeThird} <= 5'h00;
		else if (clkEn)
		begin
			spindleStrobe     <= (state_r == SQ_PRESENT || state_r == SQ_STROBE) && 
				issue_r[CMD_SPINDLE] && (state_r == SQ_STROBE);
			toolStrobe        <= (state_r == SQ_STROBE) && issue_r[CMD_TOOL];
			mcodeStrobeFirst  <= (state_r == SQ_STROBE) && issue_r[CMD_M1];
			mcodeStrobeSecond <= (state_r == SQ_STROBE) && issue_r[CMD_M1 + 1];
			mcodeStrobeThird  <= (state_r == SQ_STROBE) && issue_r[CMD_M1 + 2];
		end
	end

	// ----------------------------------------
	// Code outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{spindleCode, gearSelectBits, toolCode, mcodeFirst, mcodeSecond,
				mcodeThird} <= 132'h0;
		else if (clkEn)
		begin
			if (state_r == SQ_IDLE && startSeq)
			begin
				if (issueNxt[CMD_SPINDLE] && ctrl_r[CTRL_ANALOG])
				begin
					spindleCode    <= spinVal_r;
					gearSelectBits <= gearNxt;
				end
				else if (issueNxt[CMD_SPINDLE])
					spindleCode <= 32'h0000_0001 << (spinVal_r[2:0] - 3'h1);
				if (issueNxt[CMD_TOOL])
					toolCode <= (toolVal_r > TOOL_MAX) ? TOOL_MAX : toolVal_r;
				if (issueNxt[CMD_M1])
					mcodeFirst <= mVal_r[0];
				if (issueNxt[CMD_M1 + 1])
					mcodeSecond <= mVal_r[1][15:0];
				if (issueNxt[CMD_M1 + 2])
					mcodeThird <= mVal_r[2][15:0];
			end
			else if (finishSeq)
				{spindleCode, gearSelectBits, toolCode, mcodeFirst, mcodeSecond,
					mcodeThird} <= 132'h0;
		end
	end

	// ----------------------------------------
	// Internal spindle state and analog value
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{spinState_r, spindleAnalogValue} <= 64'h0;
		else if (clkEn && startSeq && hwdata[CMD_SPINDLE] && !spinBad)
		begin
			spinState_r <= spinVal_r;
			if (ctrl_r[CTRL_ANALOG])
				spindleAnalogValue <= spinVal_r;
		end
	end

	// ----------------------------------------
	// Status flags (set wins over clear)
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{blockDone_r, alarm_r} <= 2'h0;
		else if (clkEn)
		begin
			if (finishSeq || (startSeq && issueNxt == 5'h00))
				blockDone_r <= 1'b1;
			else if (startSeq || (wrPend_r && wrAddr_r == OFS_STATUS && hwdata[ST_BLOCK_DONE]))
				blockDone_r <= 1'b0;
			if (startSeq && hwdata[CMD_SPINDLE] && spinBad)
				alarm_r <= 1'b1;
			else if (wrPend_r && wrAddr_r == OFS_STATUS && hwdata[ST_ALARM])
				alarm_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb
	begin
		hrdata = 32'h0000_0000;
		case (wrAddr_r)
			OFS_CTRL:                hrdata = ctrl_r;
			OFS_SPINDLE:             hrdata = spinVal_r;
			OFS_TOOL:                hrdata = toolVal_r;
			OFS_MCODE1:              hrdata = mVal_r[0];
			OFS_MCODE2:              hrdata = mVal_r[1];
			OFS_MCODE3:              hrdata = mVal_r[2];
			OFS_GEAR_MAX0:           hrdata = gearMax_r[0];
			OFS_GEAR_MAX0 + 8'h04:   hrdata = gearMax_r[1];
			OFS_GEAR_MAX0 + 8'h08:   hrdata = gearMax_r[2];
			OFS_GEAR_MAX0 + 8'h0C:   hrdata = gearMax_r[3];
			OFS_STRB_DELAY:          hrdata = strbDelay_r;
			OFS_HOLD_TIME:           hrdata = holdTime_r;
			OFS_STATUS:
			begin
				hrdata[ST_BUSY]       = auxBusy;
				hrdata[ST_BLOCK_DONE] = blockDone_r;
				hrdata[ST_ALARM]      = alarm_r;
			end
			OFS_LOCK_IN:             hrdata[LOCK_IN_BIT] = lockReg_r;
			OFS_LOCK_ECHO:           hrdata[LOCK_ECHO_BIT] = auxLockEcho;
			OFS_SPIN_STATE:          hrdata = spinState_r;
			default:                 hrdata = 32'h0000_0000;
		endcase
	end

	// Motion and other codes are not held by this block; auxBusy only gates block advance

endmodule // afsh_strobe_handshake
